// ---- hw/dlsr_top.sv ----
// Data lane status bank: Avalon-MM slave, per-lane status words, interrupt.
// Assumes lane state machines on core_clk drive the lane ports directly.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module dlsr_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Avalon-MM slave
   input wire logic [dlsr_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Lane state, two mode bits per lane
   input wire logic [2*dlsr_pkg::NUM_LANES-1:0] lane_mode,
   input wire logic [dlsr_pkg::NUM_LANES-1:0] lane_stop,
   input wire logic [dlsr_pkg::NUM_LANES-1:0] lane_init_done,
   input wire logic [dlsr_pkg::NUM_LANES-1:0] lane_ultra_low_power_flag,
   input wire logic [dlsr_pkg::NUM_LANES-1:0] pkt_done,
   input wire logic [dlsr_pkg::NUM_LANES-1:0] hs_byte,
   // Role and clock lane state
   input wire logic receiver_cfg,
   input wire logic clk_lane_hs,
   // Outputs to the core
   output logic soft_reset_out,
   output logic irq
);
   import dlsr_pkg::*;

   logic ack_q;
   logic req;
   logic accept;
   logic wr_acc;
   logic rd_acc;
   logic soft_reset_bit_q;
   logic cnt_clr;
   logic [31:0] hs_limit_q;
   logic [31:0] esc_limit_q;
   logic [2:0] active_lanes_q;
   logic [7:0] irq_status_q;
   logic [7:0] irq_mask_q;
   logic [7:0] irq_events;
   logic [31:0] rd_mux;
   logic lane_hit;
   logic [7:0] lane_ofs;
   logic [1:0] lane_idx;
   logic [31:0] lane_word [NUM_LANES];
   logic [NUM_LANES-1:0] hs_ev;
   logic [NUM_LANES-1:0] esc_ev;
   logic [NUM_LANES-1:0] clr_hs;
   logic [NUM_LANES-1:0] clr_esc;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b+:8] = new_v[8*b+:8];
         end
      end
      return res;
   endfunction : be_merge

   // ****************************************************
   // Bus handshake
   // ****************************************************
   // Every access holds one wait cycle so read data comes from a flop
   assign req = avs_read || avs_write;
   assign avs_waitrequest = req && !ack_q;
   assign accept = req && ack_q;
   assign wr_acc = clk_en && accept && avs_write;
   assign rd_acc = clk_en && accept && avs_read;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else if (clk_en) begin
         ack_q <= req && !ack_q;
      end
   end

   // ****************************************************
   // Address decode
   // ****************************************************
   assign lane_ofs = avs_address - OFS_LANE_FIRST;
   assign lane_idx = lane_ofs[3:2];
   assign lane_hit = avs_address >= OFS_LANE_FIRST && avs_address <= OFS_LANE_LAST
                     && avs_address[1:0] == 2'b00;

   always_comb begin
      rd_mux = 32'h0;
      if (lane_hit) begin
         rd_mux = lane_word[lane_idx];
      end else begin
         case (avs_address)
            OFS_HS_LIMIT: rd_mux = hs_limit_q;
            OFS_ESC_LIMIT: rd_mux = esc_limit_q;
            OFS_ACTIVE_LANES: rd_mux = {29'h0, active_lanes_q};
            OFS_IRQ_STATUS: rd_mux = {24'h0, irq_status_q};
            OFS_IRQ_MASK: rd_mux = {24'h0, irq_mask_q};
            default: rd_mux = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0;
      end else if (clk_en && avs_read && !ack_q) begin
         avs_readdata <= rd_mux;
      end
   end

   // ****************************************************
   // Configuration registers
   // ****************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hs_limit_q <= HS_LIMIT_RESET;
         esc_limit_q <= ESC_LIMIT_RESET_NS;
         active_lanes_q <= ACTIVE_LANES_RESET;
         irq_mask_q <= IRQ_RESET;
      end else if (wr_acc) begin
         case (avs_address)
            OFS_HS_LIMIT: hs_limit_q <= be_merge(hs_limit_q, avs_writedata, avs_byteenable);
            OFS_ESC_LIMIT: esc_limit_q <= be_merge(esc_limit_q, avs_writedata,
                                                   avs_byteenable);
            OFS_ACTIVE_LANES: begin
               if (avs_byteenable[0]) begin
                  active_lanes_q <= avs_writedata[2:0];
               end
            end
            OFS_IRQ_MASK: begin
               if (avs_byteenable[0]) begin
                  irq_mask_q <= avs_writedata[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   // ****************************************************
   // Soft reset
   // ****************************************************
   // Self-clearing: the bit always reads zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         soft_reset_bit_q <= 1'b0;
      end else if (clk_en) begin
         soft_reset_bit_q <= wr_acc && avs_address == OFS_CTRL && avs_byteenable[0]
                   && avs_writedata[POS_SOFT_RESET];
      end
   end

   assign soft_reset_out = soft_reset_bit_q;
   // Receiver counters only follow reset while the clock lane runs high-speed
   assign cnt_clr = soft_reset_bit_q && (!receiver_cfg || clk_lane_hs);

   // ****************************************************
   // Lanes
   // ****************************************************
   for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
      assign clr_hs[i] = wr_acc && lane_hit && lane_idx == i && avs_byteenable[0]
                         && avs_writedata[POS_HS_FLAG];
      assign clr_esc[i] = wr_acc && lane_hit && lane_idx == i && avs_byteenable[0]
                          && avs_writedata[POS_ESC_FLAG];

      dlsr_lane u_lane (
         .core_clk(core_clk),
         .reset_n(reset_n),
         .clk_en(clk_en),
         .soft_rst(soft_reset_bit_q),
         .cnt_clr(cnt_clr),
         .lane_mode(dlsr_mode_t'(lane_mode[2*i+:2])),
         .lane_stop(lane_stop[i]),
         .lane_init_done(lane_init_done[i]),
         .lane_ultra_low_power_flag(lane_ultra_low_power_flag[i]),
         .pkt_done(pkt_done[i]),
         .hs_byte(hs_byte[i]),
         .hs_limit(hs_limit_q),
         .esc_limit(esc_limit_q),
         .active_lanes(active_lanes_q),
         .clr_hs(clr_hs[i]),
         .clr_esc(clr_esc[i]),
         .status_word(lane_word[i]),
         .hs_event(hs_ev[i]),
         .esc_event(esc_ev[i])
      );
   end

   // ****************************************************
   // Interrupt status and mask
   // ****************************************************
   // Low nibble high-speed timeouts, high nibble escape timeouts
   assign irq_events = {esc_ev, hs_ev};

   // Read clears only bits the read returned; later events survive
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_q <= IRQ_RESET;
      end else if (clk_en) begin
         if (soft_reset_bit_q) begin
            irq_status_q <= IRQ_RESET;
         end else if (rd_acc && avs_address == OFS_IRQ_STATUS) begin
            irq_status_q <= (irq_status_q & ~avs_readdata[7:0]) | irq_events;
         end else begin
            irq_status_q <= irq_status_q | irq_events;
         end
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_wait_one_cycle: assert property (
      req && !ack_q && clk_en ##1 req |-> !avs_waitrequest)
      else $error("wait state longer than one cycle");
   a_lane_read_data: assert property (
      avs_read && !avs_waitrequest && avs_address == OFS_LANE_FIRST
      && $past(avs_read) && $past(clk_en)
      |-> avs_readdata == $past(lane_word[0]))
      else $error("lane 0 read data wrong");
   a_count_step: assert property (
      clk_en && pkt_done[3] && !cnt_clr && lane_word[3][31:16] != COUNT_MAX
      |=> lane_word[3][31:16] == $past(lane_word[3][31:16]) + 16'h0001)
      else $error("packet count did not step");
   a_count_saturate: assert property (
      lane_word[3][31:16] == COUNT_MAX && !cnt_clr |=> lane_word[3][31:16] == COUNT_MAX)
      else $error("packet count left saturation");
   a_count_freeze: assert property (
      !clk_en |=> lane_word[1][31:16] == $past(lane_word[1][31:16]))
      else $error("packet count moved while clock enable low");
   a_count_clear: assert property (
      clk_en && cnt_clr |=> lane_word[3][31:16] == COUNT_RESET)
      else $error("packet count not cleared");
   a_count_rx_hold: assert property (
      clk_en && soft_reset_bit_q && receiver_cfg && !clk_lane_hs && !pkt_done[1]
      |=> lane_word[1][31:16] == $past(lane_word[1][31:16]))
      else $error("receiver count cleared without high-speed clock lane");
   a_stop_bit: assert property (lane_word[2][POS_STOP] == lane_stop[2])
      else $error("stop bit mismatch");
   a_esc_sets: assert property (clk_en && esc_ev[2] |=> lane_word[2][POS_ESC_FLAG])
      else $error("escape flag not set by timeout");
   a_esc_to_irq: assert property (
      clk_en && esc_ev[2] |=> irq_status_q[6])
      else $error("escape timeout not recorded in interrupt status");
   a_esc_zero_keep: assert property (
      wr_acc && lane_hit && lane_idx == 2'd2 && !avs_writedata[POS_ESC_FLAG]
      && lane_word[2][POS_ESC_FLAG] && !soft_reset_bit_q
      |=> lane_word[2][POS_ESC_FLAG])
      else $error("zero write cleared escape flag");
   a_esc_one_clear: assert property (
      wr_acc && lane_hit && lane_idx == 2'd2 && avs_byteenable[0]
      && avs_writedata[POS_ESC_FLAG] && !esc_ev[2]
      |=> !lane_word[2][POS_ESC_FLAG])
      else $error("one write did not clear escape flag");
   a_hs_sticky: assert property (
      clk_en && lane_word[0][POS_HS_FLAG] && !clr_hs[0] && !soft_reset_bit_q
      |=> lane_word[0][POS_HS_FLAG] [*1])
      else $error("high-speed flag dropped");
   a_init_ulp_bits: assert property (
      lane_word[1][POS_INIT_DONE] == lane_init_done[1]
      && lane_word[1][POS_ULP] == lane_ultra_low_power_flag[1])
      else $error("init or ultra-low-power bit mismatch");
   a_mode_bits: assert property (lane_word[3][1:0] == lane_mode[7:6])
      else $error("mode bits mismatch");
   a_hs_to_irq: assert property (
      clk_en && hs_ev[0] |=> lane_word[0][POS_HS_FLAG] && irq_status_q[0])
      else $error("high-speed timeout not recorded");
   a_soft_reset: assert property (
      clk_en && soft_reset_bit_q |=> lane_word[2][5:4] == 2'b00 && irq_status_q == IRQ_RESET)
      else $error("soft reset left flags set");
   a_rsvd_zero: assert property (lane_word[2][15:7] == 9'h000)
      else $error("reserved bits not zero");

   c_read_done: cover property (avs_read && !avs_waitrequest);
   c_hs_timeout: cover property (hs_ev[0]);
   c_escape_watchdog_limit: cover property (esc_ev[2]);
   c_count_full: cover property (lane_word[3][31:16] == COUNT_MAX);
endmodule : dlsr_top

// ---- common/dlsr_pkg.sv ----
// Constants, register map and lane mode codes for the data lane status bank.
// Assumes a single 40 MHz control clock and byte-addressed Avalon-MM access.

package dlsr_pkg;
   localparam int unsigned NUM_LANES = 4;
   localparam int unsigned ADDR_W = 8;

   // ****************************************************
   // Register offsets (byte addresses)
   // ****************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_HS_LIMIT = 8'h10;
   localparam logic [7:0] OFS_ESC_LIMIT = 8'h14;
   localparam logic [7:0] OFS_LANE_FIRST = 8'h1c;
   localparam logic [7:0] OFS_LANE_LAST = 8'h28;
   localparam logic [7:0] OFS_ACTIVE_LANES = 8'h2c;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h34;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int unsigned POS_COUNT_LO = 16;
   localparam int unsigned POS_STOP = 6;
   localparam int unsigned POS_ESC_FLAG = 5;
   localparam int unsigned POS_HS_FLAG = 4;
   localparam int unsigned POS_INIT_DONE = 3;
   localparam int unsigned POS_ULP = 2;
   localparam int unsigned POS_SOFT_RESET = 0;

   // ****************************************************
   // Reset values and limits
   // ****************************************************
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [31:0] HS_LIMIT_RESET = 32'h0001_0005;
   localparam logic [31:0] ESC_LIMIT_RESET_NS = 32'h0000_6400;
   localparam logic [2:0] ACTIVE_LANES_RESET = 3'h4;
   localparam logic [7:0] IRQ_RESET = 8'h00;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int unsigned CLK_FREQ_MHZ = 40;
   localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
   localparam logic [31:0] ESC_STEP_NS = 32'(CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      DLSR_MODE_LP = 2'b00,
      DLSR_MODE_HS = 2'b01,
      DLSR_MODE_ESC = 2'b10
   } dlsr_mode_t;
endpackage : dlsr_pkg

// ---- hw/dlsr_lane.sv ----
// One data lane: packet counter, both watchdogs and the sticky timeout flags.
// Assumes lane inputs come from same-clock logic, already registered.
`timescale 1ns/10ps
module dlsr_lane (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic soft_rst,
   input wire logic cnt_clr,
   // Lane state
   input wire dlsr_pkg::dlsr_mode_t lane_mode,
   input wire logic lane_stop,
   input wire logic lane_init_done,
   input wire logic lane_ultra_low_power_flag,
   input wire logic pkt_done,
   input wire logic hs_byte,
   // Configuration
   input wire logic [31:0] hs_limit,
   input wire logic [31:0] esc_limit,
   input wire logic [2:0] active_lanes,
   // Flag clears
   input wire logic clr_hs,
   input wire logic clr_esc,
   // Status
   output logic [31:0] status_word,
   output logic hs_event,
   output logic esc_event
);
   import dlsr_pkg::*;

   logic [15:0] count_q;
   logic [31:0] hs_acc_q;
   logic [31:0] esc_acc_q;
   logic hs_fired_q;
   logic esc_fired_q;
   logic hs_flag_q;
   logic esc_flag_q;
   logic [31:0] hs_next;
   logic [31:0] esc_next;

   // ****************************************************
   // Packet counter
   // ****************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= COUNT_RESET;
      end else if (clk_en) begin
         if (cnt_clr) begin
            count_q <= COUNT_RESET;
         end else if (pkt_done && count_q != COUNT_MAX) begin
            count_q <= count_q + 16'h0001;
         end
      end
   end

   // ****************************************************
   // Watchdogs
   // ****************************************************
   // Bytes times lanes against the frame limit avoids a divider
   assign hs_next = hs_acc_q + {29'h0, active_lanes};
   assign esc_next = esc_acc_q + ESC_STEP_NS;
   assign hs_event = !soft_rst && lane_mode == DLSR_MODE_HS && hs_byte && !hs_fired_q
                     && hs_next >= hs_limit;
   assign esc_event = !soft_rst && lane_mode == DLSR_MODE_ESC && !esc_fired_q
                      && esc_next >= esc_limit;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hs_acc_q <= 32'h0;
         hs_fired_q <= 1'b0;
      end else if (clk_en) begin
         if (soft_rst || lane_mode != DLSR_MODE_HS) begin
            hs_acc_q <= 32'h0;
            hs_fired_q <= 1'b0;
         end else if (hs_byte && !hs_fired_q) begin
            hs_acc_q <= hs_next;
            hs_fired_q <= hs_event;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         esc_acc_q <= 32'h0;
         esc_fired_q <= 1'b0;
      end else if (clk_en) begin
         if (soft_rst || lane_mode != DLSR_MODE_ESC) begin
            esc_acc_q <= 32'h0;
            esc_fired_q <= 1'b0;
         end else if (!esc_fired_q) begin
            esc_acc_q <= esc_next;
            esc_fired_q <= esc_event;
         end
      end
   end

   // ****************************************************
   // Sticky flags, set beats clear
   // ****************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hs_flag_q <= 1'b0;
         esc_flag_q <= 1'b0;
      end else if (clk_en) begin
         hs_flag_q <= !soft_rst && (hs_event || (hs_flag_q && !clr_hs));
         esc_flag_q <= !soft_rst && (esc_event || (esc_flag_q && !clr_esc));
      end
   end

   always_comb begin
      status_word = 32'h0;
      status_word[31:POS_COUNT_LO] = count_q;
      status_word[POS_STOP] = lane_stop;
      status_word[POS_ESC_FLAG] = esc_flag_q;
      status_word[POS_HS_FLAG] = hs_flag_q;
      status_word[POS_INIT_DONE] = lane_init_done;
      status_word[POS_ULP] = lane_ultra_low_power_flag;
      status_word[1:0] = lane_mode;
   end
endmodule : dlsr_lane

// ---- verification/data_lane_status_regs_tb.sv ----
// Self-checking bench for the data lane status bank, driving dlsr_top directly.
// Assumes dlsr_top answers every Avalon-MM request through waitrequest.
`timescale 1ns/10ps
module data_lane_status_regs_tb;
   import dlsr_pkg::*;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end

   // ****************************************************
   // Signals
   // ****************************************************
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] lane_mode = 8'h00;
   logic [3:0] lane_stop = 4'h0;
   logic [3:0] lane_init_done = 4'h0;
   logic [3:0] lane_ultra_low_power_flag = 4'h0;
   logic [3:0] pkt_done = 4'h0;
   logic [3:0] hs_byte = 4'h0;
   logic receiver_cfg = 1'b0;
   logic clk_lane_hs = 1'b0;
   logic soft_reset_out;
   logic irq;
   int miscompares = 0;
   int num_checks = 0;
   logic [31:0] exp_q[$];
   logic [31:0] seed;
   logic [31:0] exp_v;

   always #12.5 core_clk = ~core_clk;

   dlsr_top dut_u (
      .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .lane_mode(lane_mode), .lane_stop(lane_stop), .lane_init_done(lane_init_done),
      .lane_ultra_low_power_flag(lane_ultra_low_power_flag), .pkt_done(pkt_done), .hs_byte(hs_byte),
      .receiver_cfg(receiver_cfg), .clk_lane_hs(clk_lane_hs),
      .soft_reset_out(soft_reset_out), .irq(irq)
   );

   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Expected lane word from the lane inputs as currently driven
   function automatic logic [31:0] lw(input int i, input logic [15:0] c, input logic e,
                                      input logic h);
      return {c, 9'h000, lane_stop[i], e, h, lane_init_done[i], lane_ultra_low_power_flag[i], lane_mode[2*i+:2]};
   endfunction : lw

   task automatic finish_test;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   // One Avalon-MM transfer; a read leaves its expectation in the queue
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                      input logic [31:0] e);
      int n;
      n = 0;
      if (!wr) begin
         exp_q.push_back(e);
      end
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         miscompares++;
         $display("[ERR] %0t no bus answer", $time);
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cycles

   task automatic soft_reset;
      logic seen;
      seen = 1'b0;
      bus(OFS_CTRL, 1'b1, 32'h1, 32'h0);
      repeat (4) begin
         @(negedge core_clk);
         seen = seen | soft_reset_out;
      end
      `CHK(seen, 1'b1)
      cycles(3);
   endtask : soft_reset

   // Read data is judged at the accepting edge, where it stands
   always @(posedge core_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("[ERR] %0t read without expectation", $time);
         end else begin
            exp_v = exp_q.pop_front();
            `CHK(avs_readdata, exp_v)
         end
      end
   end

   initial begin
      #(25 * 90000);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      seed = 32'd75975;
      cycles(20);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         bus(OFS_LANE_FIRST + 8'(4 * i), 1'b0, 32'h0, 32'h0);
      end
      bus(8'h3c, 1'b0, 32'h0, 32'h0);
      bus(OFS_HS_LIMIT, 1'b0, 32'h0, HS_LIMIT_RESET);
      bus(OFS_ESC_LIMIT, 1'b0, 32'h0, ESC_LIMIT_RESET_NS);
      // Huge escape limit keeps the watchdog quiet during static checks
      bus(OFS_ESC_LIMIT, 1'b1, 32'hffff_ffff, 32'h0);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         @(posedge core_clk);
         lane_stop <= seed[3:0];
         lane_init_done <= seed[7:4];
         lane_ultra_low_power_flag <= seed[11:8];
         lane_mode <= {2'(k), 2'((k + 1) % 3), 2'((k + 2) % 3), 2'(k)};
         cycles(2);
         for (int i = 0; i < 4; i++) begin
            bus(OFS_LANE_FIRST + 8'(4 * i), 1'b0, 32'h0, lw(i, 16'h0, 1'b0, 1'b0));
         end
      end
      bus(OFS_LANE_FIRST, 1'b1, 32'hffff_ffcf, 32'h0);
      bus(OFS_LANE_FIRST, 1'b0, 32'h0, lw(0, 16'h0, 1'b0, 1'b0));
      @(posedge core_clk);
      lane_stop <= 4'h0;
      lane_init_done <= 4'h0;
      lane_ultra_low_power_flag <= 4'h0;
      lane_mode <= 8'h00;
      // Packet counting and saturation
      repeat (3) begin
         @(posedge core_clk);
         pkt_done <= 4'h2;
         @(posedge core_clk);
         pkt_done <= 4'h0;
      end
      // Frozen clock enable must swallow these packets
      @(posedge core_clk);
      clk_en <= 1'b0;
      pkt_done <= 4'h2;
      cycles(2);
      clk_en <= 1'b1;
      pkt_done <= 4'h0;
      @(posedge core_clk);
      pkt_done <= 4'h8;
      cycles(65540);
      pkt_done <= 4'h0;
      cycles(2);
      bus(8'h20, 1'b0, 32'h0, lw(1, 16'h0003, 1'b0, 1'b0));
      bus(8'h28, 1'b0, 32'h0, lw(3, COUNT_MAX, 1'b0, 1'b0));
      // Escape watchdog, sticky flag, interrupt mask and read-clear
      bus(OFS_ESC_LIMIT, 1'b1, 32'd100, 32'h0);
      @(posedge core_clk);
      lane_mode <= 8'h20;
      cycles(12);
      bus(8'h24, 1'b0, 32'h0, lw(2, 16'h0, 1'b1, 1'b0));
      @(negedge core_clk);
      `CHK(irq, 1'b0)
      bus(OFS_IRQ_MASK, 1'b1, 32'h40, 32'h0);
      @(negedge core_clk);
      `CHK(irq, 1'b1)
      bus(OFS_IRQ_STATUS, 1'b0, 32'h0, 32'h40);
      @(negedge core_clk);
      `CHK(irq, 1'b0)
      bus(8'h24, 1'b1, 32'h0, 32'h0);
      bus(8'h24, 1'b0, 32'h0, lw(2, 16'h0, 1'b1, 1'b0));
      bus(8'h24, 1'b1, 32'h20, 32'h0);
      bus(8'h24, 1'b0, 32'h0, lw(2, 16'h0, 1'b0, 1'b0));
      // High-speed watchdog: four lanes, limit of eight bytes
      bus(OFS_HS_LIMIT, 1'b1, 32'd8, 32'h0);
      @(posedge core_clk);
      lane_mode <= 8'h01;
      for (int p = 0; p < 2; p++) begin
         @(posedge core_clk);
         hs_byte <= 4'h1;
         @(posedge core_clk);
         hs_byte <= 4'h0;
         cycles(2);
         bus(OFS_LANE_FIRST, 1'b0, 32'h0, lw(0, 16'h0, 1'b0, 1'(p)));
      end
      bus(OFS_LANE_FIRST, 1'b1, 32'h10, 32'h0);
      bus(OFS_LANE_FIRST, 1'b0, 32'h0, lw(0, 16'h0, 1'b0, 1'b0));
      // Soft reset in receiver role, clock lane first low-power then high-speed
      @(posedge core_clk);
      lane_mode <= 8'h20;
      cycles(12);
      lane_mode <= 8'h00;
      receiver_cfg <= 1'b1;
      @(negedge core_clk);
      `CHK(irq, 1'b1)
      soft_reset();
      `CHK(irq, 1'b0)
      bus(8'h24, 1'b0, 32'h0, lw(2, 16'h0, 1'b0, 1'b0));
      bus(8'h28, 1'b0, 32'h0, lw(3, COUNT_MAX, 1'b0, 1'b0));
      @(posedge core_clk);
      clk_lane_hs <= 1'b1;
      soft_reset();
      bus(8'h28, 1'b0, 32'h0, lw(3, COUNT_RESET, 1'b0, 1'b0));
      cycles(4);
      finish_test();
   end
endmodule : data_lane_status_regs_tb
